// [common/fmdu_pkg.sv]
// Constants and types shared by the fixed/floating multiply-divide unit
`default_nettype none
package fmdu_pkg;

  localparam int FMDU_WORD_W = 32;

  // Instruction codes handled by the unit
  localparam logic [7:0] FMDU_OP_MUL_ACC = 8'h6c;
  localparam logic [7:0] FMDU_OP_MUL_BASE = 8'h68;
  localparam logic [7:0] FMDU_OP_MUL_IDX = 8'h6a;
  localparam logic [7:0] FMDU_OP_MULI_ACC = 8'h7c;
  localparam logic [7:0] FMDU_OP_MULI_BASE = 8'h78;
  localparam logic [7:0] FMDU_OP_MULI_IDX = 8'h7a;
  localparam logic [7:0] FMDU_OP_MUL_HALF = 8'h6d;
  localparam logic [7:0] FMDU_OP_MULI_HALF = 8'h7d;
  localparam logic [7:0] FMDU_OP_FMUL = 8'h6e;
  localparam logic [7:0] FMDU_OP_FMUL_PAIR = 8'h6f;
  localparam logic [7:0] FMDU_OP_DIV = 8'h64;
  localparam logic [7:0] FMDU_OP_DIVI = 8'h74;

  // Opcode bit that marks the immediate forms
  localparam int FMDU_IMM_BIT = 4;
  // Register-select bit that picks vector over index words
  localparam int FMDU_VEC_BIT = 3;
  // Product bits that must agree for a 32-bit result
  localparam int FMDU_OVF_TOP = 33;

  // Hex floating point: sign, excess-64 exponent, fraction
  localparam logic signed [9:0] FMDU_FLT_BIAS = 10'sd64;
  localparam logic signed [9:0] FMDU_FLT_EXP_MAX = 10'sd127;

  // Register map (byte addresses)
  localparam logic [7:0] FMDU_CTRL_OFS = 8'h00;
  localparam logic [7:0] FMDU_STAT_OFS = 8'h04;
  localparam logic [7:0] FMDU_MASK_OFS = 8'h08;
  localparam logic [7:0] FMDU_LAST_OFS = 8'h0c;
  localparam int FMDU_CTRL_EN_BIT = 0;
  localparam logic [31:0] FMDU_CTRL_RST = 32'h0000_0001;
  localparam int FMDU_EVT_W = 5;
  localparam logic [4:0] FMDU_STAT_RST = 5'h00;
  localparam logic [4:0] FMDU_MASK_RST = 5'h00;

  typedef enum logic [1:0] {
    FMDU_FILE_ACC,
    FMDU_FILE_BASE,
    FMDU_FILE_INDEX,
    FMDU_FILE_VECTOR
  } fmdu_file_t;

  typedef struct packed {
    logic less_flag;
    logic greater_flag;
    logic equal_flag;
  } fmdu_code_t;

  // Same layout as the status and mask registers, bit 4 down to 0
  typedef struct packed {
    logic fix_ovf;
    logic div_check;
    logic spec_err;
    logic flt_ovf;
    logic flt_unf;
  } fmdu_evt_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] rsel;
    logic [31:0] reg_word;
    logic [31:0] reg_word_odd;
    logic [31:0] mem_word;
    logic [31:0] mem_word_lo;
    logic [31:0] imm_word;
    logic [15:0] imm_half;
  } fmdu_issue_t;

  typedef struct packed {
    logic valid;
    fmdu_file_t file;
    logic [3:0] index;
    logic pair;
    logic [31:0] word_hi;
    logic [31:0] word_lo;
  } fmdu_wb_t;

endpackage : fmdu_pkg
`default_nettype wire

// [logic/fmdu_unit.sv]
// Multiply and divide execution datapath with result code and event flags
//
// Operation
// - 6C, even select: full 64-bit product to the accumulator pair.
// - 6C, odd select: low 32 product bits to that odd accumulator word.
// - 68: low 32 product bits back to the base pointer, any parity.
// - 6A: select 0-7 index words, 8-F vector count words; low 32 bits.
// - 7C, 78, 7A act as 6C, 68, 6A with the word immediate multiplier.
// - Flags (less, greater, equal) follow result sign: negative, positive, zero.
// - Multiply overflow when top 33 product bits are not all equal.
// - Overflow on 6C/7C only for odd select; always checked on 68/6A/78/7A.
// - 6D/7D: left half times halfword, 32-bit product, never an event.
// - 6E: single float product into accumulator word, float over/underflow.
// - 6F: double float product into pair; odd select is specification error.
// - 64 even: 64-bit pair dividend, quotient to even word, odd word kept.
// - Odd select divide: 32-bit dividend and quotient in that odd word.
// - Even select divide overflows when quotient exceeds 32 bits.
// - Zero divisor gives divide-check; a zero quotient is still written.
// - 74 follows the divide rules with the word immediate as divisor.
// - Halfword immediate is the joined operand fields, top bit the sign.
`timescale 1ns/100ps
`default_nettype none
module fmdu_unit (
  input wire logic core_clk, // Processor clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire fmdu_pkg::fmdu_issue_t issue, // Decoded instruction and operands
  input wire logic issue_valid, // Instruction offered
  output logic issue_ready, // Instruction taken this cycle
  output var fmdu_pkg::fmdu_wb_t result, // Register write-back
  output var fmdu_pkg::fmdu_code_t result_code, // Less, greater, equal
  output var fmdu_pkg::fmdu_evt_t intr_pulse, // Interruption pulses
  output logic irq, // Level interrupt
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata // AHB read data
);
  import fmdu_pkg::*;

  // Multiply an excess-64 hex fraction pair; returns ovf, unf, 64-bit value
  function automatic logic [65:0] fmdu_fmul(input logic [63:0] a,
                                            input logic [63:0] b);
    logic [111:0] p;
    logic [55:0] frac;
    logic signed [9:0] ex;
    logic [65:0] r;
    p = a[55:0] * b[55:0];
    ex = $signed({3'b000, a[62:56]}) + $signed({3'b000, b[62:56]})
         - FMDU_FLT_BIAS;
    frac = p[111:56];
    // Normalised inputs leave at most one leading zero hex digit
    if (p[111:108] == 4'h0) begin
      frac = p[107:52];
      ex = ex - 10'sd1;
    end
    if (frac == 56'h0) begin
      r = 66'h0;
    end else begin
      r = {ex > FMDU_FLT_EXP_MAX, ex < 10'sd0, a[63] ^ b[63], ex[6:0], frac};
    end
    return r;
  endfunction : fmdu_fmul

  logic [31:0] ctrl_reg;
  logic [4:0] status_reg;
  logic [4:0] mask_reg;
  logic [7:0] last_op_reg;
  logic ap_wr_reg;
  logic [7:0] ap_addr_reg;

  wire logic [7:0] op = issue.opcode;
  wire logic rs_odd = issue.rsel[0];
  wire logic is_imm = op[FMDU_IMM_BIT];
  wire logic unit_en = ctrl_reg[FMDU_CTRL_EN_BIT];
  wire logic fire = issue_valid && issue_ready;

  assign issue_ready = clk_en && unit_en;

  // Operand selection: immediate forms swap in the instruction operand
  wire logic [31:0] word_opnd = is_imm ? issue.imm_word : issue.mem_word;
  wire logic [15:0] half_opnd = is_imm ? issue.imm_half : issue.mem_word[31:16];

  // Fixed word multiply
  wire logic signed [63:0] prod = $signed(issue.reg_word) * $signed(word_opnd);
  wire logic [FMDU_OVF_TOP-1:0] prod_top = prod[63:64-FMDU_OVF_TOP];
  wire logic prod_ovf = !((&prod_top) || !(|prod_top));
  wire logic signed [63:0] imm_prod =
    $signed(issue.reg_word) * $signed(issue.imm_word);

  // Halfword multiply on the left half of the accumulator word
  wire logic signed [31:0] half_prod =
    $signed(issue.reg_word[31:16]) * $signed(half_opnd);

  // Fixed divide; odd select sign-extends a single word dividend
  wire logic [63:0] dvd = rs_odd ? {{32{issue.reg_word[31]}}, issue.reg_word}
                                 : {issue.reg_word, issue.reg_word_odd};
  wire logic div_zero = (word_opnd == 32'h0);
  // Guarding the zero case keeps the divider from producing unknowns
  wire logic signed [63:0] quot = div_zero ? 64'sh0 :
    $signed(dvd) / $signed({{32{word_opnd[31]}}, word_opnd});
  wire logic [FMDU_OVF_TOP-1:0] quot_top = quot[63:64-FMDU_OVF_TOP];
  wire logic quot_ovf = !rs_odd && !((&quot_top) || !(|quot_top));

  // Floating multiply, single uses the top word of the shared routine
  wire logic [65:0] fs_res = fmdu_fmul({issue.reg_word, 32'h0},
                                       {issue.mem_word, 32'h0});
  wire logic [65:0] fd_res = fmdu_fmul({issue.reg_word, issue.reg_word_odd},
                                       {issue.mem_word, issue.mem_word_lo});

  fmdu_wb_t wb_next;
  fmdu_evt_t evt_next;
  logic [63:0] code_val;

  always_comb begin
    wb_next = '0;
    evt_next = '0;
    code_val = 64'h0;
    wb_next.file = FMDU_FILE_ACC;
    wb_next.index = issue.rsel;
    unique case (op)
      FMDU_OP_MUL_ACC, FMDU_OP_MULI_ACC: begin
        wb_next.valid = 1'b1;
        wb_next.pair = !rs_odd;
        wb_next.word_hi = rs_odd ? prod[31:0] : prod[63:32];
        wb_next.word_lo = prod[31:0];
        code_val = rs_odd ? {{32{prod[31]}}, prod[31:0]} : prod;
        evt_next.fix_ovf = rs_odd && prod_ovf;
      end
      FMDU_OP_MUL_BASE, FMDU_OP_MULI_BASE: begin
        wb_next.valid = 1'b1;
        wb_next.file = FMDU_FILE_BASE;
        wb_next.word_hi = prod[31:0];
        code_val = {{32{prod[31]}}, prod[31:0]};
        evt_next.fix_ovf = prod_ovf;
      end
      FMDU_OP_MUL_IDX, FMDU_OP_MULI_IDX: begin
        wb_next.valid = 1'b1;
        wb_next.file = issue.rsel[FMDU_VEC_BIT] ? FMDU_FILE_VECTOR
                                                : FMDU_FILE_INDEX;
        wb_next.index = {1'b0, issue.rsel[2:0]};
        wb_next.word_hi = prod[31:0];
        code_val = {{32{prod[31]}}, prod[31:0]};
        evt_next.fix_ovf = prod_ovf;
      end
      FMDU_OP_MUL_HALF, FMDU_OP_MULI_HALF: begin
        wb_next.valid = 1'b1;
        wb_next.word_hi = half_prod;
        code_val = {{32{half_prod[31]}}, half_prod};
      end
      FMDU_OP_FMUL: begin
        wb_next.valid = 1'b1;
        wb_next.word_hi = fs_res[63:32];
        code_val = (fs_res[55:32] == 24'h0) ? 64'h0 :
                   {{63{fs_res[63]}}, 1'b1};
        evt_next.flt_ovf = fs_res[65];
        evt_next.flt_unf = fs_res[64];
      end
      FMDU_OP_FMUL_PAIR: begin
        if (rs_odd) begin
          evt_next.spec_err = 1'b1;
        end else begin
          wb_next.valid = 1'b1;
          wb_next.pair = 1'b1;
          wb_next.word_hi = fd_res[63:32];
          wb_next.word_lo = fd_res[31:0];
          code_val = (fd_res[55:0] == 56'h0) ? 64'h0 :
                     {{63{fd_res[63]}}, 1'b1};
          evt_next.flt_ovf = fd_res[65];
          evt_next.flt_unf = fd_res[64];
        end
      end
      FMDU_OP_DIV, FMDU_OP_DIVI: begin
        // Odd word of an even pair is never written, so it keeps the dividend
        wb_next.valid = 1'b1;
        wb_next.word_hi = quot[31:0];
        code_val = {{32{quot[31]}}, quot[31:0]};
        evt_next.fix_ovf = quot_ovf;
        evt_next.div_check = div_zero;
      end
      default: begin
        wb_next.valid = 1'b0;
      end
    endcase
  end

  fmdu_code_t code_next;
  assign code_next.less_flag = code_val[63];
  assign code_next.equal_flag = (code_val == 64'h0);
  assign code_next.greater_flag = !code_val[63] && (code_val != 64'h0);

  // Result stage: write-back and events leave together, one cycle after issue
  always_ff @(posedge core_clk) begin
    if (reset) begin
      result <= '0;
      result_code <= 3'b001;
      intr_pulse <= '0;
      last_op_reg <= 8'h00;
    end else if (clk_en) begin
      result <= fire ? wb_next : '0;
      intr_pulse <= fire ? evt_next : '0;
      if (fire && wb_next.valid) begin
        result_code <= code_next;
        last_op_reg <= op;
      end
    end
  end

  // Register bus: zero wait state, read data captured in the address phase
  wire logic ahb_take = hsel && hready && htrans[1];
  wire logic [31:0] rd_mux =
    (haddr[7:0] == FMDU_CTRL_OFS) ? ctrl_reg :
    (haddr[7:0] == FMDU_STAT_OFS) ? {27'h0, status_reg} :
    (haddr[7:0] == FMDU_MASK_OFS) ? {27'h0, mask_reg} :
    (haddr[7:0] == FMDU_LAST_OFS) ? {21'h0, result_code, last_op_reg} :
    32'h0;
  wire logic ctrl_wr = ap_wr_reg && (ap_addr_reg == FMDU_CTRL_OFS);
  wire logic stat_wr = ap_wr_reg && (ap_addr_reg == FMDU_STAT_OFS);
  wire logic mask_wr = ap_wr_reg && (ap_addr_reg == FMDU_MASK_OFS);
  wire logic [4:0] stat_clr = stat_wr ? hwdata[4:0] : 5'h00;
  wire logic [4:0] stat_set = fire ? evt_next : 5'h00;
  // A new event beats a write-one-to-clear in the same cycle
  wire logic [4:0] status_next = (status_reg & ~stat_clr) | stat_set;

  // Stalling with the clock enable keeps the master in step with frozen state
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata <= 32'h0;
    end else if (clk_en) begin
      ap_wr_reg <= ahb_take && hwrite;
      ap_addr_reg <= haddr[7:0];
      if (ahb_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= FMDU_CTRL_RST;
      status_reg <= FMDU_STAT_RST;
      mask_reg <= FMDU_MASK_RST;
    end else if (clk_en) begin
      status_reg <= status_next;
      if (ctrl_wr) begin
        ctrl_reg <= {31'h0, hwdata[FMDU_CTRL_EN_BIT]};
      end
      if (mask_wr) begin
        mask_reg <= hwdata[4:0];
      end
    end
  end

  chk_pair_product: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_MUL_ACC && !rs_odd |=>
      result.valid && result.pair
      && {result.word_hi, result.word_lo} == $past(prod))
    else $error("even select multiply did not store full product");

  chk_odd_low_word: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_MUL_ACC && rs_odd |=>
      result.valid && !result.pair && result.index == $past(issue.rsel)
      && result.word_hi == $past(prod[31:0]))
    else $error("odd select multiply wrote wrong word");

  chk_base_low: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_MUL_BASE |=>
      result.file == FMDU_FILE_BASE && !result.pair
      && result.word_hi == $past(prod[31:0]))
    else $error("base pointer multiply result wrong");

  chk_index_vector: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && (op == FMDU_OP_MUL_IDX || op == FMDU_OP_MULI_IDX) |=>
      result.index[2:0] == $past(issue.rsel[2:0])
      && (result.file == FMDU_FILE_VECTOR) == $past(issue.rsel[3]))
    else $error("index or vector word selected wrongly");

  chk_imm_operand: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_MULI_ACC && !rs_odd |=>
      {result.word_hi, result.word_lo} == $past(imm_prod))
    else $error("immediate multiply did not use immediate operand");

  chk_code_sign: assert property (
    @(posedge core_clk) disable iff (reset)
    result.valid && !result.pair |->
      $onehot(result_code) && result_code.less_flag == result.word_hi[31]
      && result_code.equal_flag == (result.word_hi == 32'h0))
    else $error("result code does not match stored word");

  chk_mul_ovf: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && (op == FMDU_OP_MUL_BASE || op == FMDU_OP_MULI_IDX) |=>
      intr_pulse.fix_ovf == $past(!(&prod[63:31] || !(|prod[63:31]))))
    else $error("multiply overflow mismatch");

  chk_pair_no_ovf: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_MULI_ACC && !rs_odd |=> !intr_pulse.fix_ovf)
    else $error("overflow raised for full length product");

  chk_half_quiet: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && (op == FMDU_OP_MUL_HALF || op == FMDU_OP_MULI_HALF) |=>
      intr_pulse == '0 && result.word_hi == $past(half_prod))
    else $error("halfword multiply result or event wrong");

  chk_float_spec: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_FMUL_PAIR && rs_odd |=>
      intr_pulse.spec_err && !result.valid)
    else $error("odd double float multiply not refused");

  chk_div_zero: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && (op == FMDU_OP_DIV || op == FMDU_OP_DIVI) && div_zero |=>
      intr_pulse.div_check && result.valid && !result.pair
      && result.word_hi == 32'h0)
    else $error("zero divisor handling wrong");

  chk_div_even: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_DIV && !rs_odd && !div_zero |=>
      !result.pair && result.word_hi == $past(quot[31:0])
      && intr_pulse.fix_ovf == $past(quot_ovf))
    else $error("even divide quotient or overflow wrong");

  chk_odd_divide: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && (op == FMDU_OP_DIV || op == FMDU_OP_DIVI) && rs_odd |=>
      result.valid && !result.pair && !intr_pulse.fix_ovf
      && result.index == $past(issue.rsel))
    else $error("odd select divide wrote wrong target");

  chk_imm_divisor: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_DIVI |=>
      intr_pulse.div_check == ($past(issue.imm_word) == 32'h0))
    else $error("immediate divide did not use immediate divisor");

  chk_half_imm: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_MULI_HALF |=>
      result.word_hi == $past(
        $signed({{16{issue.reg_word[31]}}, issue.reg_word[31:16]})
        * $signed({{16{issue.imm_half[15]}}, issue.imm_half})))
    else $error("halfword immediate operand taken wrongly");

  chk_float_write: assert property (
    @(posedge core_clk) disable iff (reset)
    fire && op == FMDU_OP_FMUL |=>
      result.valid && !result.pair && result.file == FMDU_FILE_ACC
      && !intr_pulse.fix_ovf && !intr_pulse.div_check
      && !(intr_pulse.flt_ovf && intr_pulse.flt_unf))
    else $error("single float multiply target or events wrong");

  // A pulse may only persist when a new instruction was taken behind it
  chk_evt_sticky: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && intr_pulse != '0 |->
      (status_reg & intr_pulse) == intr_pulse
      ##1 ($past(fire) || intr_pulse == '0))
    else $error("event pulse not one cycle or not latched");

endmodule : fmdu_unit
`default_nettype wire

// [test/fmdu_issuer.sv]
// Model of the instruction pipeline that offers work to the unit
`timescale 1ns/100ps
`default_nettype none
module fmdu_issuer (
  input wire logic core_clk, // Processor clock
  output var fmdu_pkg::fmdu_issue_t issue, // Offered instruction
  output logic issue_valid, // Offer strobe
  input wire logic issue_ready // Unit takes the offer
);
  import fmdu_pkg::*;
  initial begin
    issue = '0;
    issue_valid = 1'b0;
  end
  // Idle operands are inverted so stale data never looks like a live offer
  task automatic send(input fmdu_issue_t w);
    @(posedge core_clk);
    issue <= w;
    issue_valid <= 1'b1;
    @(posedge core_clk);
    while (issue_ready !== 1'b1) @(posedge core_clk);
    issue <= ~w;
    issue_valid <= 1'b0;
  endtask : send
endmodule : fmdu_issuer
`default_nettype wire

// [test/fmdu_unit_tb.sv]
// Self-checking testbench for the multiply-divide unit
`timescale 1ns/100ps
`default_nettype none
module fmdu_unit_tb;
  import fmdu_pkg::*;
  logic core_clk, reset, clk_en, hsel, hwrite, hreadyout, hresp;
  logic issue_valid, issue_ready, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  fmdu_issue_t issue;
  fmdu_wb_t result;
  fmdu_code_t result_code;
  fmdu_evt_t intr_pulse;
  int num_errors = 0;
  int cmp_count = 0;

  fmdu_issuer u_iss (.core_clk(core_clk), .issue(issue),
    .issue_valid(issue_valid), .issue_ready(issue_ready));
  fmdu_unit u_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .issue(issue), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .result(result), .result_code(result_code), .intr_pulse(intr_pulse),
    .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Single word transfer; the address phase is held until ready is seen
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask : ahb

  // Issue one instruction; returns 1 ns after the edge that took it
  task automatic iss(input logic [7:0] o, input logic [3:0] r,
    input logic [31:0] rw, ro, mw, ml, iw, input logic [15:0] ih);
    u_iss.send('{o, r, rw, ro, mw, ml, iw, ih});
    #1;
  endtask : iss

  task automatic exp_wb(input logic v, input fmdu_file_t f,
    input logic [3:0] ix, input logic pr, input logic [63:0] val,
    input logic [4:0] ev, input logic cw);
    logic [63:0] sv;
    logic [2:0] c;
    sv = pr ? val : {{32{val[31]}}, val[31:0]};
    c = sv[63] ? 3'b100 : (sv == 64'h0) ? 3'b001 : 3'b010;
    check(result.valid === v && intr_pulse === ev, "valid or event");
    if (v) check(result.file === f && result.index === ix &&
                 result.pair === pr, "write target");
    if (v && cw) begin
      check(result.word_hi === (pr ? val[63:32] : val[31:0]), "word_hi");
      if (pr) check(result.word_lo === val[31:0], "word_lo");
      check(result_code === c, "result code");
    end
  endtask : exp_wb

  task automatic t_reset;
    check(result_code === 3'b001 && irq === 1'b0 && hresp === 1'b0,
          "reset outputs");
    ahb(1'b0, FMDU_CTRL_OFS, 32'h0, rd);
    check(rd === FMDU_CTRL_RST, "ctrl reset");
    ahb(1'b0, FMDU_STAT_OFS, 32'h0, rd);
    check(rd === {27'h0, FMDU_STAT_RST}, "status reset");
    ahb(1'b0, FMDU_MASK_OFS, 32'h0, rd);
    check(rd === {27'h0, FMDU_MASK_RST}, "mask reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_mul;
    logic [7:0] ops [10] = '{8'h6c, 8'h6c, 8'h7c, 8'h7c, 8'h68, 8'h78,
                             8'h6a, 8'h6a, 8'h7a, 8'h7a};
    logic [3:0] rs [10] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h1, 4'h6, 4'h5,
                            4'hc, 4'h0, 4'hf};
    logic [31:0] av [3] = '{32'h0001_0000, 32'hffff_fffd, 32'h0};
    logic [31:0] bv [3] = '{32'h0001_0000, 32'h0000_0005, 32'h0000_1234};
    logic signed [63:0] x, y, p;
    logic imm, pr, ov;
    fmdu_file_t f;
    logic [3:0] ix;
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 3; j++) begin
        imm = ops[i][FMDU_IMM_BIT];
        x = $signed(av[j]);
        y = $signed(bv[j]);
        p = x * y;
        ov = !((&p[63:31]) || !(|p[63:31]));
        f = ops[i][1] ? (rs[i][FMDU_VEC_BIT] ? FMDU_FILE_VECTOR :
            FMDU_FILE_INDEX) : ops[i][2] ? FMDU_FILE_ACC : FMDU_FILE_BASE;
        ix = ops[i][1] ? {1'b0, rs[i][2:0]} : rs[i];
        pr = (f == FMDU_FILE_ACC) && !rs[i][0];
        // The unused operand slot carries a decoy so a wrong pick shows
        iss(ops[i], rs[i], av[j], 32'h0, imm ? 32'h3 : bv[j], 32'h0,
            imm ? bv[j] : 32'h3, 16'h0);
        exp_wb(1'b1, f, ix, pr, p, {ov && !pr, 4'h0}, 1'b1);
      end
    end
    $display("test multiply done");
  endtask : t_mul

  task automatic t_half;
    iss(FMDU_OP_MUL_HALF, 4'h1, 32'h8000_1234, 32'h0, 32'h8000_5678,
        32'h0, 32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h1, 1'b0, 64'h4000_0000, 5'h0, 1'b1);
    iss(FMDU_OP_MULI_HALF, 4'h2, 32'h7fff_0000, 32'h0, 32'h0002_0000,
        32'h0, 32'h0, 16'hffff);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h2, 1'b0, 64'hffff_8001, 5'h0, 1'b1);
    $display("test halfword done");
  endtask : t_half

  task automatic t_div;
    iss(FMDU_OP_DIV, 4'h2, 32'h1, 32'h0, 32'h10, 32'h0, 32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h2, 1'b0, 64'h1000_0000, 5'h0, 1'b1);
    iss(FMDU_OP_DIV, 4'h3, 32'hffff_ff9c, 32'h0, 32'h7, 32'h0, 32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h3, 1'b0, 64'hffff_fff2, 5'h0, 1'b1);
    iss(FMDU_OP_DIVI, 4'h4, 32'h0, 32'h64, 32'h3, 32'h0, 32'hffff_fffb,
        16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h4, 1'b0, 64'hffff_ffec, 5'h0, 1'b1);
    iss(FMDU_OP_DIVI, 4'h4, 32'h10, 32'h0, 32'h3, 32'h0, 32'h1, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h4, 1'b0, 64'h0, 5'h10, 1'b0);
    iss(FMDU_OP_DIV, 4'h5, 32'h8000_0000, 32'h0, 32'hffff_ffff, 32'h0,
        32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h5, 1'b0, 64'h8000_0000, 5'h0, 1'b1);
    iss(FMDU_OP_DIV, 4'h6, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h6, 1'b0, 64'h0, 5'h08, 1'b1);
    $display("test divide done");
  endtask : t_div

  task automatic t_float;
    iss(FMDU_OP_FMUL, 4'h1, 32'h4110_0000, 32'h0, 32'h4110_0000, 32'h0,
        32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h1, 1'b0, 64'h4110_0000, 5'h0, 1'b1);
    iss(FMDU_OP_FMUL, 4'h1, 32'h0, 32'h0, 32'h4110_0000, 32'h0, 32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h1, 1'b0, 64'h0, 5'h0, 1'b1);
    iss(FMDU_OP_FMUL, 4'h1, 32'h7f10_0000, 32'h0, 32'h7f10_0000, 32'h0,
        32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h1, 1'b0, 64'h0, 5'h02, 1'b0);
    iss(FMDU_OP_FMUL, 4'h1, 32'h0110_0000, 32'h0, 32'h0110_0000, 32'h0,
        32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h1, 1'b0, 64'h0, 5'h01, 1'b0);
    iss(FMDU_OP_FMUL_PAIR, 4'h2, 32'h4110_0000, 32'h0, 32'h4110_0000,
        32'h0, 32'h0, 16'h0);
    exp_wb(1'b1, FMDU_FILE_ACC, 4'h2, 1'b1, 64'h4110_0000_0000_0000, 5'h0,
           1'b1);
    iss(FMDU_OP_FMUL_PAIR, 4'h3, 32'h4110_0000, 32'h0, 32'h4110_0000,
        32'h0, 32'h0, 16'h0);
    exp_wb(1'b0, FMDU_FILE_ACC, 4'h3, 1'b0, 64'h0, 5'h04, 1'b0);
    $display("test float done");
  endtask : t_float

  task automatic t_irq;
    ahb(1'b1, FMDU_STAT_OFS, 32'h1f, rd);
    ahb(1'b1, FMDU_MASK_OFS, 32'h10, rd);
    ahb(1'b0, FMDU_STAT_OFS, 32'h0, rd);
    check(rd === 32'h0 && irq === 1'b0, "status clear");
    iss(FMDU_OP_DIV, 4'h1, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 16'h0);
    check(irq === 1'b0, "masked event raised irq");
    iss(FMDU_OP_MUL_ACC, 4'h3, 32'h0001_0000, 32'h0, 32'h0001_0000, 32'h0,
        32'h0, 16'h0);
    check(irq === 1'b1, "unmasked event missed");
    @(posedge core_clk);
    #1;
    check(intr_pulse === 5'h0 && result.valid === 1'b0, "pulse width");
    ahb(1'b0, FMDU_LAST_OFS, 32'h0, rd);
    check(rd === {21'h0, 3'b001, FMDU_OP_MUL_ACC}, "last register");
    ahb(1'b0, FMDU_STAT_OFS, 32'h0, rd);
    check(rd === 32'h18, "status sticky bits");
    ahb(1'b1, FMDU_STAT_OFS, 32'h10, rd);
    ahb(1'b0, FMDU_STAT_OFS, 32'h0, rd);
    check(rd === 32'h08 && irq === 1'b0, "write one to clear");
    ahb(1'b0, 8'h10, 32'h0, rd);
    check(rd === 32'h0, "unmapped read");
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_refuse;
    ahb(1'b1, FMDU_CTRL_OFS, 32'h0, rd);
    #1;
    check(issue_ready === 1'b0, "disabled unit ready");
    ahb(1'b1, FMDU_CTRL_OFS, 32'h1, rd);
    clk_en <= 1'b0;
    @(posedge core_clk);
    #1;
    check(issue_ready === 1'b0 && hreadyout === 1'b0, "frozen unit ready");
    @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    #1;
    check(issue_ready === 1'b1, "ready after enable");
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    ahb(1'b0, FMDU_MASK_OFS, 32'h0, rd);
    check(rd === {27'h0, FMDU_MASK_RST} && irq === 1'b0, "mid-run reset");
    $display("test refusal done");
  endtask : t_refuse

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reset;
    t_mul;
    t_half;
    t_div;
    t_float;
    t_irq;
    t_refuse;
    final_report;
  end

  // The whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    final_report;
  end
endmodule : fmdu_unit_tb
`default_nettype wire
